// file: rtl/ulc_line_ctrl.sv
// Purpose: one serial channel: framing, flow modes, faults, break, pin mux
// Assumes: bit time fixed by ULC_BIT_CYC; rx_full comes from the rx buffer
// Notes: all state sits in one struct, registered once per clock
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
module ulc_line_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [ulc_pkg::ULC_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // transmit stream
  input wire logic [8:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // receive stream
  output logic [8:0] rx_data,
  output logic rx_valid,
  input wire logic rx_full,
  // serial line
  input wire logic rxd,
  output logic txd,
  // general pins
  input wire logic [5:0] gp_in,
  output logic [5:0] gp_out,
  output logic [5:0] gp_oe,
  output logic pin_event,
  output logic [5:0] pin_event_bits
);
  import ulc_pkg::*;

  typedef struct packed {
    logic [7:0] frame, flow, xon, xoff, brk, dly, pfn, dir, msk, addr;
    logic [5:0] gpo;
    logic [6:3] flags;
    logic brk_live;
    logic [7:0] rdata;
    logic rx_s1, rx_s2;
    logic [5:0] gp_s1, gp_s2, gp_prev;
    ulc_tx_type tx_st;
    logic [7:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [11:0] tx_sh;
    logic txd;
    logic paused, matched;
    ulc_rx_type rx_st;
    logic [7:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [11:0] rx_sh;
    logic [8:0] rx_data;
    logic rx_valid;
    logic pin_event;
    logic [5:0] pin_bits;
  } ulc_state_type;

  ulc_state_type q, d;
  logic nine, par_on, two_stop, go, de_act, blocked, accept;
  logic [3:0] nd, total;
  logic [2:0] mode, psel;
  logic [5:0] tk_in, tk_out, fout, chg;
  logic [8:0] mk;

  // parity bit of the masked data for the chosen kind
  function automatic logic par_bit(input logic [8:0] dv, input logic [2:0] sel);
    logic r;
    r = 1'b0;
    unique case (sel)
      ULC_PODD: r = ~^dv;
      ULC_PEVEN: r = ^dv;
      ULC_PMARK: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : par_bit

  // character shape; reserved width codes fall back to eight bits
  always_comb begin
    nine = q.frame[3:0] == ULC_W9;
    nd = (q.frame[3:0] == ULC_W7) ? 4'd7 : (nine ? 4'd9 : 4'd8);
    mk = (q.frame[3:0] == ULC_W7) ? 9'h07f : (nine ? 9'h1ff : 9'h0ff);
    psel = q.frame[6:4];
    par_on = !nine && psel != ULC_PNONE && psel <= ULC_PSPACE;
    two_stop = q.frame[7];
    total = 4'd1 + nd + {3'd0, par_on} + (two_stop ? 4'd2 : 4'd1);
    mode = q.flow[2:0];
  end

  // transmit permission from flow mode, handshakes, address match and break
  always_comb begin
    go = 1'b1;
    if (mode == ULC_MD_SW && q.paused) begin
      go = 1'b0;
    end
    if (mode == ULC_MD_HW && q.pfn[2:0] == ULC_PF_RTS && q.gp_s2[4]) begin
      go = 1'b0;
    end
    if (mode == ULC_MD_HW && q.pfn[2:0] == ULC_PF_DTR && q.gp_s2[2]) begin
      go = 1'b0;
    end
    if (mode == ULC_MD_BOTH && !q.matched) begin
      go = 1'b0;
    end
    if (q.brk != ULC_ZERO) begin
      go = 1'b0;
    end
    tx_ready = q.tx_st == TX_IDLE && go;
    accept = tx_ready && tx_valid;
    blocked = q.flow[3] && q.tx_st != TX_IDLE;
    de_act = (q.tx_st == TX_LEAD || q.tx_st == TX_SHIFT || q.tx_st == TX_HOLD)
      && (q.pfn[2:0] != ULC_PF_XM || q.matched);
  end

  // pin takeover by the selected function
  always_comb begin
    tk_in = 6'h00;
    tk_out = 6'h00;
    fout = 6'h00;
    unique case (q.pfn[2:0])
      ULC_PF_RTS: begin
        tk_in[4] = 1'b1;
        tk_out[5] = 1'b1;
        fout[5] = rx_full; // ready to receive shows as low
      end
      ULC_PF_DTR: begin
        tk_in[2] = 1'b1;
        tk_out[3] = 1'b1;
        fout[3] = rx_full;
      end
      ULC_PF_XCVR, ULC_PF_XM: begin
        tk_out[5] = 1'b1;
        fout[5] = de_act ? q.pfn[3] : !q.pfn[3];
      end
      default: begin
        tk_in = 6'h00;
      end
    endcase
    gp_oe = tk_out | (q.dir[5:0] & ~tk_in & ~tk_out);
    gp_out = (tk_out & fout) | (~tk_out & q.gpo);
    chg = (q.gp_s2 ^ q.gp_prev) & ~gp_oe & ~tk_in & ~q.msk[5:0];
  end

  // next state
  always_comb begin
    logic [11:0] sh;
    logic [8:0] dv;
    logic pb, s1, s2;
    sh = 12'h000;
    dv = 9'h000;
    pb = 1'b0;
    s1 = 1'b1;
    s2 = 1'b1;
    d = q;
    d.rx_valid = 1'b0;
    d.rx_s1 = rxd;
    d.rx_s2 = q.rx_s1;
    d.gp_s1 = gp_in;
    d.gp_s2 = q.gp_s1;
    d.gp_prev = q.gp_s2;
    d.pin_event = |chg;
    d.pin_bits = chg;
    // register writes; flow mode is trusted to change only while idle
    if (reg_wr) begin
      unique case (reg_addr)
        ULC_FRAME: d.frame = reg_wdata;
        ULC_FLOW: d.flow = reg_wdata;
        ULC_RESUME: d.xon = reg_wdata;
        ULC_PAUSE: d.xoff = reg_wdata;
        ULC_BREAK: d.brk = reg_wdata;
        ULC_TURN: d.dly = reg_wdata;
        ULC_PINFN: d.pfn = reg_wdata;
        ULC_DIR: d.dir = reg_wdata;
        ULC_MASK: d.msk = reg_wdata;
        ULC_SET: d.gpo = q.gpo | reg_wdata[5:0];
        ULC_ADDR: d.addr = reg_wdata;
        default: d.addr = q.addr;
      endcase
    end
    // reads answer next cycle; unmapped reads as zero
    unique case (reg_addr)
      ULC_FRAME: d.rdata = q.frame;
      ULC_FLOW: d.rdata = q.flow;
      ULC_RESUME: d.rdata = q.xon;
      ULC_PAUSE: d.rdata = q.xoff;
      ULC_FAULT: d.rdata = {q.brk_live, q.flags, 3'h0};
      ULC_BREAK: d.rdata = q.brk;
      ULC_TURN: d.rdata = q.dly;
      ULC_PINFN: d.rdata = q.pfn;
      ULC_DIR: d.rdata = q.dir;
      ULC_MASK: d.rdata = q.msk;
      ULC_SET: d.rdata = {2'h0, q.gpo};
      ULC_ADDR: d.rdata = q.addr;
      default: d.rdata = ULC_ZERO;
    endcase
    // clear first so that a set in the same cycle wins
    if (reg_rd && reg_addr == ULC_FAULT) begin
      d.flags = 4'h0;
    end
    // transmitter
    unique case (q.tx_st)
      TX_IDLE: begin
        if (q.brk != ULC_ZERO) begin
          d.tx_st = TX_BRK;
          d.txd = 1'b0;
        end else if (accept) begin
          sh = 12'hfff;
          sh[0] = 1'b0;
          for (int i = 0; i < 9; i++) begin
            if (i < nd) begin
              sh[i+1] = tx_data[i];
            end
          end
          if (par_on) begin
            sh[nd+4'd1] = par_bit(tx_data & mk, psel);
          end
          d.tx_sh = sh;
          d.tx_bit = total;
          d.tx_cnt = ULC_BIT_CYC;
          d.tx_st = TX_LEAD;
        end
      end
      TX_LEAD: begin
        d.tx_st = TX_SHIFT;
        d.txd = q.tx_sh[0];
      end
      TX_SHIFT: begin
        if (q.tx_cnt == 8'h00) begin
          d.tx_cnt = ULC_BIT_CYC;
          d.tx_sh = {1'b1, q.tx_sh[11:1]};
          d.tx_bit = q.tx_bit - 4'd1;
          d.txd = q.tx_sh[1];
          if (q.tx_bit == 4'd1) begin
            d.txd = 1'b1;
            d.tx_bit = q.dly[3:0];
            d.tx_st = q.flow[3] ? TX_HOLD : TX_IDLE;
          end
        end else begin
          d.tx_cnt = q.tx_cnt - 8'h01;
        end
      end
      TX_HOLD: begin
        if (q.tx_bit == 4'd0) begin
          d.tx_st = TX_IDLE;
        end else if (q.tx_cnt == 8'h00) begin
          d.tx_cnt = ULC_BIT_CYC;
          d.tx_bit = q.tx_bit - 4'd1;
        end else begin
          d.tx_cnt = q.tx_cnt - 8'h01;
        end
      end
      TX_BRK: begin
        if (q.brk == ULC_ZERO) begin
          d.tx_st = TX_IDLE;
          d.txd = 1'b1;
        end
      end
      default: begin
        d.tx_st = TX_IDLE;
        d.txd = 1'b1;
      end
    endcase
    // receiver; sampling at mid bit from the start edge
    unique case (q.rx_st)
      RX_IDLE: begin
        if (!blocked && !q.rx_s2) begin
          d.rx_st = RX_START;
          d.rx_cnt = ULC_HALF_CYC;
        end
      end
      RX_START: begin
        if (q.rx_cnt != 8'h00) begin
          d.rx_cnt = q.rx_cnt - 8'h01;
        end else if (q.rx_s2) begin
          d.rx_st = RX_IDLE; // glitch, not a start bit
        end else begin
          d.rx_st = RX_BITS;
          d.rx_cnt = ULC_BIT_CYC;
          d.rx_bit = 4'd0;
          d.rx_sh = 12'h000;
        end
      end
      RX_BITS: begin
        if (q.rx_cnt != 8'h00) begin
          d.rx_cnt = q.rx_cnt - 8'h01;
        end else begin
          sh = q.rx_sh;
          sh[q.rx_bit] = q.rx_s2;
          d.rx_sh = sh;
          d.rx_cnt = ULC_BIT_CYC;
          d.rx_bit = q.rx_bit + 4'd1;
          if (q.rx_bit == total - 4'd2) begin
            d.rx_st = RX_IDLE;
            dv = sh[8:0] & mk;
            pb = sh[nd];
            s1 = sh[nd+{3'd0, par_on}];
            s2 = two_stop ? sh[nd+{3'd0, par_on}+4'd1] : 1'b1;
            if (sh == 12'h000) begin
              d.flags[3] = 1'b1;
              d.brk_live = 1'b1;
              d.rx_st = RX_WAITHI;
            end else begin
              if (!s1 || !s2) begin
                d.flags[4] = 1'b1;
              end
              if (par_on && pb != par_bit(dv, psel)) begin
                d.flags[5] = 1'b1;
              end
              if ((mode == ULC_MD_RX || mode == ULC_MD_BOTH) && nine && dv[8]) begin
                d.matched = dv[7:0] == q.addr;
              end else if (mode == ULC_MD_SW && dv[7:0] == q.xoff) begin
                d.paused = 1'b1;
              end else if (mode == ULC_MD_SW && dv[7:0] == q.xon) begin
                d.paused = 1'b0;
              end else if ((mode != ULC_MD_RX && mode != ULC_MD_BOTH) || q.matched) begin
                d.rx_valid = 1'b1;
                d.rx_data = dv;
                if (rx_full) begin
                  d.flags[6] = 1'b1;
                end
              end
            end
          end
        end
      end
      RX_WAITHI: begin
        if (q.rx_s2) begin
          d.brk_live = 1'b0;
          d.rx_st = RX_IDLE;
        end
      end
      default: d.rx_st = RX_IDLE;
    endcase
    // half-duplex: whatever arrives while sending is thrown away
    // a break found just as sending starts keeps its wait state, so the live bit can still fall
    if (blocked && d.rx_st != RX_WAITHI) begin
      d.rx_st = RX_IDLE;
    end
  end

  // state register; line idles high after reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.frame <= ULC_FRAME_RST;
      q.txd <= 1'b1;
      q.rx_s1 <= 1'b1;
      q.rx_s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign rx_data = q.rx_data;
  assign rx_valid = q.rx_valid;
  assign txd = q.txd;
  assign pin_event = q.pin_event;
  assign pin_event_bits = q.pin_bits;

  // checks
  brk_line_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    q.tx_st == TX_BRK |-> !txd) else $error("break state without low line");
  fault_clr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_rd && reg_addr == ULC_FAULT && q.rx_st != RX_BITS |=> q.flags == 4'h0)
    else $error("fault bits survive a read");
  brk_live_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    q.brk_live |-> q.rx_st == RX_WAITHI) else $error("live break out of step");
  half_dup_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    q.flow[3] && q.tx_st == TX_SHIFT && q.rx_st != RX_WAITHI |=> q.rx_st == RX_IDLE)
    else $error("receiver active while sending half-duplex");
  pause_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode == ULC_MD_SW && q.paused |-> !tx_ready) else $error("sending while paused");
  de_lead_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    q.tx_st == TX_LEAD && q.pfn[2:0] == ULC_PF_XCVR |-> txd && gp_out[5] == q.pfn[3])
    else $error("enable not ahead of start bit");
  two_stop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    accept && q.frame == 8'hb8 |=> q.tx_bit == 4'd12) else $error("wrong frame length");
  nine_len_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    accept && nine && !q.frame[7] |=> q.tx_bit == 4'd11) else $error("parity with nine bits");
  gp_dir_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    q.pfn[2:0] == ULC_PF_GPIO |-> gp_oe == q.dir[5:0]) else $error("pin direction wrong");
endmodule : ulc_line_ctrl

// file: pkg/ulc_pkg.sv
// Purpose: shared constants and types of the serial line controller
// Assumes: 125 MHz ref_clk, fixed bit time (no rate generator here)
// Notes: register indices are word offsets on the plain register port
package ulc_pkg;
  localparam int ULC_AW = 4;
  // register offsets
  localparam logic [3:0] ULC_FRAME = 4'h0;
  localparam logic [3:0] ULC_FLOW = 4'h1;
  localparam logic [3:0] ULC_RESUME = 4'h2;
  localparam logic [3:0] ULC_PAUSE = 4'h3;
  localparam logic [3:0] ULC_FAULT = 4'h4;
  localparam logic [3:0] ULC_BREAK = 4'h5;
  localparam logic [3:0] ULC_TURN = 4'h6;
  localparam logic [3:0] ULC_PINFN = 4'h7;
  localparam logic [3:0] ULC_DIR = 4'h8;
  localparam logic [3:0] ULC_MASK = 4'h9;
  localparam logic [3:0] ULC_SET = 4'ha;
  localparam logic [3:0] ULC_ADDR = 4'hb;
  // reset values
  localparam logic [7:0] ULC_FRAME_RST = 8'h08;
  localparam logic [7:0] ULC_ZERO = 8'h00;
  // data width codes
  localparam logic [3:0] ULC_W7 = 4'h7;
  localparam logic [3:0] ULC_W9 = 4'h9;
  // parity codes
  localparam logic [2:0] ULC_PNONE = 3'h0;
  localparam logic [2:0] ULC_PODD = 3'h1;
  localparam logic [2:0] ULC_PEVEN = 3'h2;
  localparam logic [2:0] ULC_PMARK = 3'h3;
  localparam logic [2:0] ULC_PSPACE = 3'h4;
  // flow modes
  localparam logic [2:0] ULC_MD_HW = 3'h1;
  localparam logic [2:0] ULC_MD_SW = 3'h2;
  localparam logic [2:0] ULC_MD_RX = 3'h3;
  localparam logic [2:0] ULC_MD_BOTH = 3'h4;
  // pin functions
  localparam logic [2:0] ULC_PF_GPIO = 3'h0;
  localparam logic [2:0] ULC_PF_RTS = 3'h1;
  localparam logic [2:0] ULC_PF_DTR = 3'h2;
  localparam logic [2:0] ULC_PF_XCVR = 3'h3;
  localparam logic [2:0] ULC_PF_XM = 3'h4;
  // bit time
  localparam int ULC_CLK_NS = 8;
  localparam int ULC_BIT_NS = 1000;
  localparam logic [7:0] ULC_BIT_CYC = 8'(ULC_BIT_NS / ULC_CLK_NS - 1);
  localparam logic [7:0] ULC_HALF_CYC = 8'(ULC_BIT_NS / ULC_CLK_NS / 2 - 1);
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_LEAD = 3'b001, TX_SHIFT = 3'b011,
    TX_HOLD = 3'b010, TX_BRK = 3'b110
  } ulc_tx_type;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b11, RX_WAITHI = 2'b10
  } ulc_rx_type;
endpackage : ulc_pkg

// file: test/ulc_peer.sv
// Purpose: remote serial station on the far side of the line
// Assumes: fixed bit time of ULC_BIT_CYC+1 clocks
// Notes: drives mark between frames, the level a pulled-up line rests at
`timescale 1ns/100ps
module ulc_peer (
  // clock
  input wire logic ref_clk,
  // serial line
  input wire logic txd,
  output logic rxd
);
  import ulc_pkg::*;
  localparam int BT = int'(ULC_BIT_CYC) + 1;
  logic [15:0] got;
  initial rxd = 1'b1;
  // send n bits lsb first, start bit included, then rest at mark
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BT) @(posedge ref_clk);
    end
    rxd <= 1'b1;
  endtask : send
  // wait for a start bit, then sample n bits at mid-bit
  task automatic grab(input int n);
    got = '0;
    while (txd !== 1'b0) @(posedge ref_clk);
    repeat (BT / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      repeat (BT) @(posedge ref_clk);
      got[i] = txd;
    end
  endtask : grab
endmodule : ulc_peer

// file: test/ulc_line_ctrl_tb.sv
// Purpose: self-checking bench for the serial line controller
// Assumes: peer model on the line, 125 clocks per bit
// Notes: one task per scenario; the watchdog shares the closing task
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module ulc_line_ctrl_tb;
  import ulc_pkg::*;
  localparam int BT = int'(ULC_BIT_CYC) + 1;
  logic ref_clk, rstn, reg_wr, reg_rd, tx_valid, rx_full, tx_ready, rx_valid, rxd, txd, pin_event;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [8:0] tx_data, rx_data, last_rx;
  logic [5:0] gp_in, gp_out, gp_oe, pin_event_bits, ev_bits;
  int num_errors, total_checks, rx_cnt, ev_cnt;
  ulc_line_ctrl dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_full(rx_full), .rxd(rxd), .txd(txd),
    .gp_in(gp_in), .gp_out(gp_out), .gp_oe(gp_oe), .pin_event(pin_event), .pin_event_bits(pin_event_bits));
  ulc_peer peer_u (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // collect delivered characters and pin events on the quiet edge
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      last_rx = rx_data;
    end
    if (pin_event === 1'b1) begin
      ev_cnt++;
      ev_bits = pin_event_bits;
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic chkreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg read", e, reg_rdata)
  endtask : chkreg
  // wait whole bit times, then step off the edge
  task automatic wait_bits(input int n);
    repeat (n * BT) @(posedge ref_clk);
    #1;
  endtask : wait_bits
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  // hold the character until ready is seen high before an edge
  task automatic send_tx(input logic [8:0] d);
    @(posedge ref_clk);
    tx_data <= d;
    tx_valid <= 1'b1;
    #7;
    while (tx_ready !== 1'b1) begin
      @(posedge ref_clk);
      #7;
    end
    @(posedge ref_clk);
    tx_valid <= 1'b0;
  endtask : send_tx
  task automatic t_regs();
    chkreg(ULC_FRAME, 8'h08);
    chkreg(ULC_FAULT, 8'h00);
    chkreg(4'hc, 8'h00);
    wr(ULC_RESUME, 8'h5a);
    chkreg(ULC_RESUME, 8'h5a);
  endtask : t_regs
  // widths, parity kinds and stop counts; bit length proven by ready timing
  task automatic t_frames();
    logic [7:0] fr [5] = '{8'h08, 8'h97, 8'h29, 8'hb8, 8'h48};
    logic [8:0] dt [5] = '{9'h0a5, 9'h035, 9'h1a5, 9'h00f, 9'h0ff};
    logic [15:0] ex [5] = '{16'h01a5, 16'h03b5, 16'h03a5, 16'h070f, 16'h02ff};
    int nb [5] = '{9, 10, 10, 11, 10};
    for (int i = 0; i < 5; i++) begin
      wr(ULC_FRAME, fr[i]);
      fork
        peer_u.grab(nb[i]);
        send_tx(dt[i]);
      join
      #1;
      `CHK("tx bits", ex[i], peer_u.got)
      `CHK("busy in stop", 1'b0, tx_ready)
      wait_bits(1);
      `CHK("ready after", 1'b1, tx_ready)
    end
  endtask : t_frames
  task automatic rx_case(input logic [15:0] b, input logic [7:0] e);
    peer_u.send(b, 11);
    wait_bits(1);
    chkreg(ULC_FAULT, e);
    chkreg(ULC_FAULT, 8'h00);
  endtask : rx_case
  task automatic t_rx();
    int n0;
    wr(ULC_FRAME, 8'h18);
    n0 = rx_cnt;
    rx_case(16'h06aa, 8'h00);
    `CHK("rx count", n0 + 1, rx_cnt)
    `CHK("rx data", 9'h055, last_rx)
    rx_case(16'h04aa, 8'h20);
    rx_case(16'h02aa, 8'h10);
    rx_full <= 1'b1;
    rx_case(16'h06aa, 8'h40);
    rx_full <= 1'b0;
    fork
      peer_u.send(16'h0000, 16);
      begin
        wait_bits(13);
        chkreg(ULC_FAULT, 8'h88);
      end
    join
    wait_bits(2);
    chkreg(ULC_FAULT, 8'h00);
  endtask : t_rx
  task automatic t_flow();
    int n0;
    wr(ULC_FRAME, 8'h08);
    wr(ULC_FLOW, 8'h02);
    wr(ULC_PAUSE, 8'h13);
    wr(ULC_RESUME, 8'h11);
    n0 = rx_cnt;
    peer_u.send(16'h0226, 10);
    wait_bits(1);
    `CHK("paused", 1'b0, tx_ready)
    peer_u.send(16'h0222, 10);
    wait_bits(1);
    `CHK("resumed", 1'b1, tx_ready)
    `CHK("flow chars kept", n0, rx_cnt)
    wr(ULC_FLOW, 8'h00);
  endtask : t_flow
  // break requested while a character is still leaving
  task automatic t_brk();
    fork
      peer_u.grab(9);
      begin
        send_tx(9'h03c);
        wr(ULC_BREAK, 8'h01);
      end
    join
    `CHK("char before break", 16'h013c, peer_u.got)
    wait_bits(4);
    `CHK("break line", 1'b0, txd)
    `CHK("break busy", 1'b0, tx_ready)
    wr(ULC_BREAK, 8'h00);
    wait_bits(1);
    `CHK("break end", 1'b1, txd)
  endtask : t_brk
  task automatic t_half();
    int n0;
    wr(ULC_FLOW, 8'h08);
    wr(ULC_TURN, 8'h02);
    wr(ULC_PINFN, 8'h0b);
    n0 = rx_cnt;
    fork
      peer_u.send(16'h02aa, 10);
      begin
        send_tx(9'h000);
        #1;
        `CHK("enable leads", 2'b11, {gp_oe[5], gp_out[5]})
        `CHK("lead idle", 1'b1, txd)
        repeat (2 + 11 * BT) @(posedge ref_clk);
        #1;
        `CHK("enable in turn", 1'b1, gp_out[5])
        `CHK("busy in turn", 1'b0, tx_ready)
        repeat (BT + 2) @(posedge ref_clk);
        #1;
        `CHK("enable off", 1'b0, gp_out[5])
        `CHK("ready again", 1'b1, tx_ready)
      end
    join
    `CHK("rx dropped", n0, rx_cnt)
    wr(ULC_PINFN, 8'h03);
    settle();
    `CHK("low-active idle", 1'b1, gp_out[5])
    wr(ULC_FLOW, 8'h00);
  endtask : t_half
  // multidrop: an address character opens receive and, in mode 4, transmit and the enable
  task automatic t_mdrop();
    int n0;
    wr(ULC_FRAME, 8'h09);
    wr(ULC_ADDR, 8'h21);
    wr(ULC_PINFN, 8'h0c);
    wr(ULC_FLOW, 8'h03);
    settle();
    `CHK("rx-only tx free", 1'b1, tx_ready)
    wr(ULC_FLOW, 8'h04);
    settle();
    `CHK("unmatched tx", 1'b0, tx_ready)
    `CHK("enable idle", 1'b0, gp_out[5])
    n0 = rx_cnt;
    peer_u.send(16'h0466, 11);
    wait_bits(1);
    `CHK("unmatched rx", n0, rx_cnt)
    peer_u.send(16'h0642, 11);
    wait_bits(1);
    `CHK("address kept", n0, rx_cnt)
    `CHK("matched tx", 1'b1, tx_ready)
    peer_u.send(16'h0466, 11);
    wait_bits(1);
    `CHK("matched rx", n0 + 1, rx_cnt)
    `CHK("matched data", 9'h033, last_rx)
    send_tx(9'h155);
    #1;
    `CHK("enable on match", 2'b11, {gp_oe[5], gp_out[5]})
    wait_bits(12);
    `CHK("match enable off", 1'b0, gp_out[5])
    wr(ULC_FLOW, 8'h00);
  endtask : t_mdrop
  task automatic t_pins();
    int n0;
    wr(ULC_PINFN, 8'h00);
    wr(ULC_DIR, 8'h0f);
    wr(ULC_SET, 8'h05);
    settle();
    `CHK("dir", 6'h0f, gp_oe)
    `CHK("set", 4'h5, gp_out[3:0])
    wr(ULC_SET, 8'h02);
    settle();
    `CHK("set keeps", 4'h7, gp_out[3:0])
    rx_full <= 1'b1;
    wr(ULC_PINFN, 8'h01);
    settle();
    `CHK("rts pair", 3'b101, {gp_oe[5:4], gp_out[5]})
    wr(ULC_FLOW, 8'h01);
    gp_in <= 6'h10;
    settle();
    `CHK("cts stops tx", 1'b0, tx_ready)
    gp_in <= 6'h00;
    settle();
    `CHK("cts lets tx", 1'b1, tx_ready)
    wr(ULC_FLOW, 8'h00);
    wr(ULC_PINFN, 8'h02);
    settle();
    `CHK("dtr pair", 3'b101, {gp_oe[3:2], gp_out[3]})
    rx_full <= 1'b0;
    wr(ULC_PINFN, 8'h00);
    wr(ULC_DIR, 8'h00);
    wr(ULC_MASK, 8'h3e);
    settle();
    n0 = ev_cnt;
    gp_in <= 6'h01;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK("event count", n0 + 1, ev_cnt)
    `CHK("event pins", 6'h01, ev_bits)
    gp_in <= 6'h03;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK("masked pin", n0 + 1, ev_cnt)
  endtask : t_pins
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    {rstn, reg_wr, reg_rd, tx_valid, rx_full} = '0;
    {reg_addr, reg_wdata, tx_data, gp_in} = '0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_frames();
    t_rx();
    t_flow();
    t_brk();
    t_half();
    t_mdrop();
    t_pins();
    print_verdict();
  end
  // watchdog: the scenarios need roughly 27700 clocks
  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    $display("BAD watchdog exp done got hang");
    print_verdict();
  end
endmodule : ulc_line_ctrl_tb
